// [core/psr_top.sv]
/*
  Protocol snoop and redirect: classifies frames from parsed header
  fields and rewrites the forwarding port mask, with one APB control
  register. Assumes the forwarding path presents one header per valid
  pulse on clk_sys and accepts the result one cycle later, no stall.
*/
// Function
// - MLD query enabled by bit 17; bit 18 selects trap-only versus forward plus copy.
// - MLD report/done enabled by bit 15; bit 16 selects trap-only versus copy.
// - IGMP unknown enabled by bit 13; bit 14 selects trap-only versus copy.
// - IGMP query enabled by bit 11; bit 12 selects trap-only versus copy.
// - IGMP report/leave enabled by bit 9; bit 10 selects trap-only versus copy.
// - IGMP is IP protocol 2; bit 8 also demands class D destination.
// - ICMPv6 is next header 58, or 0 then 58; MLD excluded.
// - ICMPv6 enabled by bit 4; bit 5 selects trap-only versus copy.
// - Bit 3 adds a CPU copy to normally forwarded ICMPv4.
// - Bit 2 adds a CPU copy to normally forwarded DHCP.
// - Bit 1 adds a CPU copy to normally forwarded RARP.
// - Bit 0 adds a CPU copy to normally forwarded ARP.
`timescale 1ns/1ps
`include "psr_consts.svh"

module psr_top #(
  parameter int NUM_PORTS = 9,
  parameter int CPU_PORT = 8
) (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [`PSR_ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic hdr_valid,
  input wire psr_pkg::psr_hdr_t hdr,
  input wire logic [NUM_PORTS-1:0] l2_mask,
  output logic res_valid,
  output logic [NUM_PORTS-1:0] res_mask,
  output psr_pkg::psr_verdict_t res_verdict
);

  ////////////////////////////////////////////////////////////////////
  // Control register and APB slave

  logic [31:0] ctrl;
  logic [15:0] trap_count;
  logic [15:0] copy_count;
  logic access;
  logic hit_ctrl;
  logic hit_stat;
  logic [31:0] next_prdata;

  assign access = psel && penable;
  assign hit_ctrl = (paddr == `PSR_OFF_CTRL);
  assign hit_stat = (paddr == `PSR_OFF_STAT);

  // One wait state so that read data comes from a flip-flop
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      pready <= 1'b0;
    end else begin
      pready <= access && !pready;
    end
  end

  always_comb begin
    next_prdata = `PSR_DATA_ZERO;
    if (hit_ctrl) begin
      next_prdata = ctrl;
    end else if (hit_stat) begin
      next_prdata = {copy_count, trap_count};
    end
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      prdata <= `PSR_DATA_ZERO;
    end else if (access && !pready) begin
      prdata <= pwrite ? `PSR_DATA_ZERO : next_prdata;
    end
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      pslverr <= 1'b0;
    end else if (access && !pready) begin
      // Status is read only, so a write to it is an error as well
      pslverr <= !(hit_ctrl || (hit_stat && !pwrite));
    end else begin
      pslverr <= 1'b0;
    end
  end

  // Reserved upper bits are kept as written
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      ctrl <= `PSR_CTRL_RESET;
    end else if (access && pready && pwrite && hit_ctrl) begin
      ctrl <= pwdata;
    end
  end

  // Control fields by name
  logic mld_query_trap_only;
  logic mld_query_snoop_en;
  logic mld_report_trap_only;
  logic mld_report_snoop_en;
  logic igmp_unknown_trap_only;
  logic igmp_unknown_snoop_en;
  logic igmp_query_trap_only;
  logic igmp_query_snoop_en;
  logic igmp_report_trap_only;
  logic igmp_report_snoop_en;
  logic igmp_dest_ip_check_en;
  logic icmp6_trap_only;
  logic icmp6_snoop_en;
  logic icmp4_snoop_en;
  logic dhcp_snoop_en;
  logic rarp_snoop_en;
  logic arp_snoop_en;

  assign mld_query_trap_only = ctrl[`PSR_B_MLD_QRY_TRAP];
  assign mld_query_snoop_en = ctrl[`PSR_B_MLD_QUERY_SNOOP_EN];
  assign mld_report_trap_only = ctrl[`PSR_B_MLD_RPT_TRAP];
  assign mld_report_snoop_en = ctrl[`PSR_B_MLD_RPT_EN];
  assign igmp_unknown_trap_only = ctrl[`PSR_B_IGMP_UKN_TRAP];
  assign igmp_unknown_snoop_en = ctrl[`PSR_B_IGMP_UNKNOWN_SNOOP_EN];
  assign igmp_query_trap_only = ctrl[`PSR_B_IGMP_QRY_TRAP];
  assign igmp_query_snoop_en = ctrl[`PSR_B_IGMP_QUERY_SNOOP_EN];
  assign igmp_report_trap_only = ctrl[`PSR_B_IGMP_RPT_TRAP];
  assign igmp_report_snoop_en = ctrl[`PSR_B_IGMP_RPT_EN];
  assign igmp_dest_ip_check_en = ctrl[`PSR_B_IGMP_DEST_IP_CHECK_EN];
  assign icmp6_trap_only = ctrl[`PSR_B_ICMP6_TRAP];
  assign icmp6_snoop_en = ctrl[`PSR_B_ICMP6_EN];
  assign icmp4_snoop_en = ctrl[`PSR_B_ICMP4_EN];
  assign dhcp_snoop_en = ctrl[`PSR_B_DHCP_SNOOP_EN];
  assign rarp_snoop_en = ctrl[`PSR_B_RARP_SNOOP_EN];
  assign arp_snoop_en = ctrl[`PSR_B_ARP_SNOOP_EN];

  ////////////////////////////////////////////////////////////////////
  // Classification

  logic is_ip4;
  logic is_ip6;
  logic dip_class_d;
  logic igmp_hit;
  logic icmp6_hit;
  logic dhcp_hit;
  logic igmp_query;
  logic igmp_report;
  logic mld_query;
  logic mld_report;
  psr_pkg::psr_class_t cls;

  assign is_ip4 = (hdr.ethertype == `PSR_ETH_IP4);
  assign is_ip6 = (hdr.ethertype == `PSR_ETH_IP6);
  // Class D is 224.0.0.0 to 239.255.255.255: top nibble 1110
  assign dip_class_d = (hdr.dst_ip[31:28] == `PSR_CLASS_D_TOP);

  assign igmp_hit = is_ip4 && (hdr.ip_proto == `PSR_PROTO_IGMP)
      && (!igmp_dest_ip_check_en || dip_class_d);

  assign icmp6_hit = is_ip6 && ((hdr.ip6_next == `PSR_NH_ICMP6)
      || ((hdr.ip6_next == `PSR_NH_HOPOPT) && (hdr.ip6_ext_next == `PSR_NH_ICMP6)));

  assign dhcp_hit = is_ip4 && (hdr.ip_proto == `PSR_PROTO_UDP)
      && ((hdr.udp_dst == `PSR_UDP_BOOTPS) || (hdr.udp_dst == `PSR_UDP_BOOTPC));

  assign igmp_query = (hdr.msg_type == `PSR_IGMP_QUERY);
  assign igmp_report = (hdr.msg_type == `PSR_IGMP_REP_V1)
      || (hdr.msg_type == `PSR_IGMP_REP_V2)
      || (hdr.msg_type == `PSR_IGMP_REP_V3)
      || (hdr.msg_type == `PSR_IGMP_LEAVE);
  assign mld_query = (hdr.msg_type == `PSR_MLD_QUERY);
  assign mld_report = (hdr.msg_type == `PSR_MLD_REP_V1)
      || (hdr.msg_type == `PSR_MLD_REP_V2)
      || (hdr.msg_type == `PSR_MLD_DONE);

  always_comb begin
    cls = psr_pkg::PSR_CLS_NONE;
    if (hdr.ethertype == `PSR_ETH_ARP) begin
      cls = psr_pkg::PSR_CLS_ARP;
    end else if (hdr.ethertype == `PSR_ETH_RARP) begin
      cls = psr_pkg::PSR_CLS_RARP;
    end else if (igmp_hit) begin
      if (igmp_query) begin
        cls = psr_pkg::PSR_CLS_IGMP_QRY;
      end else if (igmp_report) begin
        cls = psr_pkg::PSR_CLS_IGMP_RPT;
      end else begin
        cls = psr_pkg::PSR_CLS_IGMP_UKN;
      end
    end else if (is_ip4 && (hdr.ip_proto == `PSR_PROTO_ICMP4)) begin
      cls = psr_pkg::PSR_CLS_ICMP4;
    end else if (dhcp_hit) begin
      cls = psr_pkg::PSR_CLS_DHCP;
    end else if (icmp6_hit) begin
      if (mld_query) begin
        cls = psr_pkg::PSR_CLS_MLD_QRY;
      end else if (mld_report) begin
        cls = psr_pkg::PSR_CLS_MLD_RPT;
      end else begin
        cls = psr_pkg::PSR_CLS_ICMP6;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Verdict per class

  logic class_en;
  logic class_trap;

  always_comb begin
    class_en = 1'b0;
    class_trap = 1'b0;
    case (cls)
      psr_pkg::PSR_CLS_MLD_QRY: begin
        class_en = mld_query_snoop_en;
        class_trap = mld_query_trap_only;
      end
      psr_pkg::PSR_CLS_MLD_RPT: begin
        class_en = mld_report_snoop_en;
        class_trap = mld_report_trap_only;
      end
      psr_pkg::PSR_CLS_IGMP_UKN: begin
        class_en = igmp_unknown_snoop_en;
        class_trap = igmp_unknown_trap_only;
      end
      psr_pkg::PSR_CLS_IGMP_QRY: begin
        class_en = igmp_query_snoop_en;
        class_trap = igmp_query_trap_only;
      end
      psr_pkg::PSR_CLS_IGMP_RPT: begin
        class_en = igmp_report_snoop_en;
        class_trap = igmp_report_trap_only;
      end
      psr_pkg::PSR_CLS_ICMP6: begin
        class_en = icmp6_snoop_en;
        class_trap = icmp6_trap_only;
      end
      psr_pkg::PSR_CLS_ICMP4: begin
        class_en = icmp4_snoop_en;
      end
      psr_pkg::PSR_CLS_DHCP: begin
        class_en = dhcp_snoop_en;
      end
      psr_pkg::PSR_CLS_RARP: begin
        class_en = rarp_snoop_en;
      end
      psr_pkg::PSR_CLS_ARP: begin
        class_en = arp_snoop_en;
      end
      default: begin
        class_en = 1'b0;
        class_trap = 1'b0;
      end
    endcase
  end

  logic do_trap;
  logic do_copy;
  logic [NUM_PORTS-1:0] cpu_bit;
  logic [NUM_PORTS-1:0] next_mask;

  assign do_trap = class_en && class_trap;
  assign do_copy = class_en && !class_trap;
  assign cpu_bit = NUM_PORTS'(1) << CPU_PORT;

  always_comb begin
    if (do_trap) begin
      next_mask = cpu_bit;
    end else if (do_copy) begin
      next_mask = l2_mask | cpu_bit;
    end else begin
      next_mask = l2_mask;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Result register, one cycle after the header

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      res_valid <= 1'b0;
    end else begin
      res_valid <= hdr_valid;
    end
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      res_mask <= '0;
    end else if (hdr_valid) begin
      res_mask <= next_mask;
    end
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      res_verdict <= '{cls: psr_pkg::PSR_CLS_NONE, cpu_copy: 1'b0, trap: 1'b0};
    end else if (hdr_valid) begin
      res_verdict <= '{cls: cls, cpu_copy: do_copy, trap: do_trap};
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Redirect counters; they wrap, software reads differences

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      trap_count <= 16'h0000;
    end else if (hdr_valid) begin
      trap_count <= trap_count + {15'h0000, do_trap};
    end
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      copy_count <= 16'h0000;
    end else if (hdr_valid) begin
      copy_count <= copy_count + {15'h0000, do_copy};
    end
  end

endmodule

// [pkg/psr_consts.svh]
/*
  Constants of the protocol snoop and redirect block: register offsets,
  control bit positions, frame field codes.
  Assumes inclusion by bare name from the package and the core.
*/
`ifndef PSR_CONSTS_SVH
`define PSR_CONSTS_SVH

`define PSR_ADDR_W 12
`define PSR_OFF_CTRL 12'h050
`define PSR_OFF_STAT 12'h054
`define PSR_CTRL_RESET 32'h0000_0000
`define PSR_DATA_ZERO 32'h0000_0000

`define PSR_B_MLD_QRY_TRAP 18
`define PSR_B_MLD_QUERY_SNOOP_EN 17
`define PSR_B_MLD_RPT_TRAP 16
`define PSR_B_MLD_RPT_EN 15
`define PSR_B_IGMP_UKN_TRAP 14
`define PSR_B_IGMP_UNKNOWN_SNOOP_EN 13
`define PSR_B_IGMP_QRY_TRAP 12
`define PSR_B_IGMP_QUERY_SNOOP_EN 11
`define PSR_B_IGMP_RPT_TRAP 10
`define PSR_B_IGMP_RPT_EN 9
`define PSR_B_IGMP_DEST_IP_CHECK_EN 8
`define PSR_B_ICMP6_TRAP 5
`define PSR_B_ICMP6_EN 4
`define PSR_B_ICMP4_EN 3
`define PSR_B_DHCP_SNOOP_EN 2
`define PSR_B_RARP_SNOOP_EN 1
`define PSR_B_ARP_SNOOP_EN 0

`define PSR_ETH_ARP 16'h0806
`define PSR_ETH_RARP 16'h8035
`define PSR_ETH_IP4 16'h0800
`define PSR_ETH_IP6 16'h86DD
`define PSR_PROTO_ICMP4 8'h01
`define PSR_PROTO_IGMP 8'h02
`define PSR_PROTO_UDP 8'h11
`define PSR_NH_HOPOPT 8'h00
`define PSR_NH_ICMP6 8'h3A
`define PSR_UDP_BOOTPS 16'h0043
`define PSR_UDP_BOOTPC 16'h0044
`define PSR_IGMP_QUERY 8'h11
`define PSR_IGMP_REP_V1 8'h12
`define PSR_IGMP_REP_V2 8'h16
`define PSR_IGMP_LEAVE 8'h17
`define PSR_IGMP_REP_V3 8'h22
`define PSR_MLD_QUERY 8'h82
`define PSR_MLD_REP_V1 8'h83
`define PSR_MLD_DONE 8'h84
`define PSR_MLD_REP_V2 8'h8F
`define PSR_CLASS_D_TOP 4'hE

`endif

// [pkg/psr_pkg.sv]
/*
  Types of the protocol snoop and redirect block.
  Assumes psr_consts.svh on the include path.
*/
`include "psr_consts.svh"

package psr_pkg;

  typedef enum logic [3:0] {
    PSR_CLS_NONE,
    PSR_CLS_ARP,
    PSR_CLS_RARP,
    PSR_CLS_DHCP,
    PSR_CLS_ICMP4,
    PSR_CLS_ICMP6,
    PSR_CLS_IGMP_QRY,
    PSR_CLS_IGMP_RPT,
    PSR_CLS_IGMP_UKN,
    PSR_CLS_MLD_QRY,
    PSR_CLS_MLD_RPT
  } psr_class_t;

  // Header fields already parsed by the forwarding path
  typedef struct packed {
    logic [15:0] ethertype;
    logic [7:0] ip_proto;
    logic [31:0] dst_ip;
    logic [7:0] ip6_next;
    logic [7:0] ip6_ext_next;
    logic [7:0] msg_type;
    logic [15:0] udp_dst;
    logic [15:0] udp_src;
  } psr_hdr_t;

  typedef struct packed {
    psr_class_t cls;
    logic cpu_copy;
    logic trap;
  } psr_verdict_t;

endpackage

// [test/psr_fwd_model.sv]
/* Forwarding path model: turns a frame kind into parsed header fields.
   Assumes send and kind are changed just after a rising edge. */
`timescale 1ns/1ps
`include "psr_consts.svh"
module psr_fwd_model (
  input wire logic clk_sys,
  input wire logic send,
  input wire logic [3:0] kind,
  input wire logic [8:0] mask_in,
  output logic hdr_valid,
  output psr_pkg::psr_hdr_t hdr,
  output logic [8:0] l2_mask
);
  initial begin
    hdr_valid = 1'b0;
    hdr = '0;
    l2_mask = '0;
  end
  // Idle fields toggle so a design that reads them off-pulse is caught
  always @(posedge clk_sys) begin
    hdr_valid <= send;
    l2_mask <= send ? mask_in : ~l2_mask;
    if (!send) begin
      hdr <= ~hdr;
    end else begin
      hdr <= '0;
      case (kind)
        4'h1: hdr.ethertype <= `PSR_ETH_ARP;
        4'h2: hdr.ethertype <= `PSR_ETH_RARP;
        4'h3, 4'h4, 4'h6, 4'h7, 4'h8, 4'hC, 4'hD, 4'hF: hdr.ethertype <= `PSR_ETH_IP4;
        default: hdr.ethertype <= `PSR_ETH_IP6;
      endcase
      hdr.ip_proto <= (kind == 4'h3 || kind == 4'hF) ? `PSR_PROTO_UDP
        : kind == 4'h4 ? `PSR_PROTO_ICMP4 : `PSR_PROTO_IGMP;
      hdr.udp_dst <= kind == 4'h3 ? `PSR_UDP_BOOTPS : kind == 4'hF ? `PSR_UDP_BOOTPC
        : 16'h0000;
      hdr.ip6_next <= kind == 4'hB ? `PSR_NH_HOPOPT : `PSR_NH_ICMP6;
      hdr.ip6_ext_next <= `PSR_NH_ICMP6;
      hdr.dst_ip <= kind == 4'hC ? 32'h0A00_0001 : 32'hE000_0001;
      case (kind)
        4'h6, 4'hC: hdr.msg_type <= `PSR_IGMP_QUERY;
        4'h7: hdr.msg_type <= `PSR_IGMP_REP_V2;
        4'h8: hdr.msg_type <= 8'h55;
        4'h9: hdr.msg_type <= `PSR_MLD_QUERY;
        4'hA: hdr.msg_type <= `PSR_MLD_DONE;
        4'hD: hdr.msg_type <= `PSR_IGMP_LEAVE;
        4'hE: hdr.msg_type <= `PSR_MLD_REP_V2;
        default: hdr.msg_type <= 8'h80;
      endcase
    end
  end
endmodule

// [test/psr_top_props.sv]
/* Port-level checker of psr_top: bus timing and result masks.
   Assumes a bind onto every psr_top instance. */
`timescale 1ns/1ps
module psr_top_props #(
  parameter int NUM_PORTS = 9,
  parameter int CPU_PORT = 8
) (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic hdr_valid,
  input wire logic [NUM_PORTS-1:0] l2_mask,
  input wire logic res_valid,
  input wire logic [NUM_PORTS-1:0] res_mask,
  input wire psr_pkg::psr_verdict_t res_verdict
);
  localparam logic [NUM_PORTS-1:0] CPU_BIT = NUM_PORTS'(1) << CPU_PORT;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (reset);
  ////////////////////////////////////////////////////////////
  property p_res_lat; hdr_valid |=> res_valid; endproperty
  a_res_lat: assert property (p_res_lat) else $error("result late");
  property p_res_pulse; !hdr_valid |=> !res_valid; endproperty
  a_res_pulse: assert property (p_res_pulse) else $error("stray result");
  property p_apb_wait; psel && !penable |-> ##2 pready; endproperty
  a_apb_wait: assert property (p_apb_wait) else $error("bus answer late");
  property p_apb_phase; pready |-> psel && penable; endproperty
  a_apb_phase: assert property (p_apb_phase) else $error("answer outside access");
  property p_apb_once; pready |=> !pready; endproperty
  a_apb_once: assert property (p_apb_once) else $error("answer held");
  property p_err; pslverr |-> pready; endproperty
  a_err: assert property (p_err) else $error("error without answer");
  property p_trap; res_valid && res_verdict.trap |-> res_mask == CPU_BIT; endproperty
  a_trap: assert property (p_trap) else $error("trap mask wrong");
  property p_copy;
    res_valid && res_verdict.cpu_copy && !res_verdict.trap |->
      res_mask == ($past(l2_mask) | CPU_BIT);
  endproperty
  a_copy: assert property (p_copy) else $error("copy mask wrong");
  property p_plain;
    res_valid && !res_verdict.cpu_copy && !res_verdict.trap |-> res_mask == $past(l2_mask);
  endproperty
  a_plain: assert property (p_plain) else $error("plain mask wrong");
  property p_hold; !res_valid |-> $stable(res_mask); endproperty
  a_hold: assert property (p_hold) else $error("mask moved");
endmodule
bind psr_top psr_top_props #(.NUM_PORTS(NUM_PORTS), .CPU_PORT(CPU_PORT)) u_psr_top_props (
  .clk_sys(clk_sys), .reset(reset), .psel(psel), .penable(penable), .pready(pready),
  .pslverr(pslverr), .hdr_valid(hdr_valid), .l2_mask(l2_mask), .res_valid(res_valid),
  .res_mask(res_mask), .res_verdict(res_verdict));

// [test/psr_top_tb.sv]
/* Self-checking bench of psr_top: register access, every class in every mode.
   Assumes the checker bind and the forwarding path model are compiled. */
`timescale 1ns/1ps
`include "psr_consts.svh"
module psr_top_tb;
  logic clk_sys, reset, psel, penable, pwrite, pready, pslverr, er;
  logic send, hdr_valid, res_valid;
  logic [`PSR_ADDR_W-1:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0] kind;
  logic [8:0] mask_in, l2_mask, res_mask;
  psr_pkg::psr_hdr_t hdr;
  psr_pkg::psr_verdict_t res_verdict;
  int n_fail = 0, tests_run = 0, cyc = 0;
  int eb[16] = '{0, 0, 1, 2, 3, 4, 11, 9, 13, 17, 15, 4, 11, 9, 15, 2};
  int tb_bit[16] = '{0, 0, 1, 2, 3, 5, 12, 10, 14, 18, 16, 5, 12, 10, 16, 2};
  int cls[16] = '{0, 1, 2, 3, 4, 5, 6, 7, 8, 9, 10, 5, 6, 7, 10, 3};
  psr_top u_psr_top (.clk_sys(clk_sys), .reset(reset), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .hdr_valid(hdr_valid), .hdr(hdr), .l2_mask(l2_mask),
    .res_valid(res_valid), .res_mask(res_mask), .res_verdict(res_verdict));
  psr_fwd_model u_psr_fwd_model (.clk_sys(clk_sys), .send(send), .kind(kind),
    .mask_in(mask_in), .hdr_valid(hdr_valid), .hdr(hdr), .l2_mask(l2_mask));
  ////////////////////////////////////////////////////////////
  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 5000) begin
      n_fail++;
      give_verdict();
    end
  end
  task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic apb(logic wr, logic [`PSR_ADDR_W-1:0] a, logic [31:0] d);
    @(posedge clk_sys);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    // Only pready or the bench timeout ends this wait
    do begin
      @(posedge clk_sys);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic frame(logic [3:0] k);
    @(posedge clk_sys);
    send <= 1'b1;
    kind <= k;
    mask_in <= 9'h0A5;
    @(posedge clk_sys);
    send <= 1'b0;
    repeat (2) @(posedge clk_sys);
    check("res_valid", 32'(res_valid), 32'h0000_0001);
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////
  initial begin
    logic [31:0] c;
    logic trap, copy;
    {psel, penable, pwrite, send, paddr, pwdata, kind, mask_in} = '0;
    reset = 1'b1;
    repeat (20) @(posedge clk_sys);
    reset <= 1'b0;
    apb(1'b0, `PSR_OFF_CTRL, 32'h0000_0000);
    check("ctrl reset", rd, `PSR_CTRL_RESET);
    apb(1'b1, `PSR_OFF_CTRL, 32'hFFF8_0000);
    check("ctrl write err", 32'(er), 32'h0000_0000);
    apb(1'b0, `PSR_OFF_CTRL, 32'h0000_0000);
    check("ctrl readback", rd, 32'hFFF8_0000);
    apb(1'b0, 12'h0F0, 32'h0000_0000);
    check("unmapped err", 32'(er), 32'h0000_0001);
    apb(1'b1, `PSR_OFF_STAT, 32'h0000_0001);
    check("status write err", 32'(er), 32'h0000_0001);
    $display("register test done");
    for (int f = 1; f < 16; f++) begin
      for (int m = 0; m < 3; m++) begin
        c = (m == 0) ? ((eb[f] != tb_bit[f]) ? 32'h0000_0001 << tb_bit[f] : '0)
          : (32'h0000_0001 << eb[f]) | ((m == 2) ? 32'h0000_0001 << tb_bit[f] : '0);
        trap = (m == 2) && (eb[f] != tb_bit[f]);
        copy = (m != 0) && !trap;
        apb(1'b1, `PSR_OFF_CTRL, c);
        frame(f[3:0]);
        check("class", 32'(res_verdict.cls), 32'(cls[f]));
        check("trap", 32'(res_verdict.trap), 32'(trap));
        check("copy", 32'(res_verdict.cpu_copy), 32'(copy));
        check("mask", 32'(res_mask), trap ? 32'h0000_0100 : copy ? 32'h0000_01A5
          : 32'h0000_00A5);
      end
    end
    $display("class test done");
    apb(1'b1, `PSR_OFF_CTRL, 32'h0000_0900);
    frame(4'hC);
    check("non class D", 32'(res_mask), 32'h0000_00A5);
    frame(4'h6);
    check("class D", 32'(res_mask), 32'h0000_01A5);
    $display("address check test done");
    // Ten traps and twenty-one copies were sent above
    apb(1'b0, `PSR_OFF_STAT, 32'h0000_0000);
    check("status counts", rd, 32'h0015_000A);
    check("status read err", 32'(er), 32'h0000_0000);
    $display("status test done");
    @(posedge clk_sys);
    reset <= 1'b1;
    repeat (3) @(posedge clk_sys);
    reset <= 1'b0;
    apb(1'b0, `PSR_OFF_CTRL, 32'h0000_0000);
    check("ctrl after reset", rd, `PSR_CTRL_RESET);
    apb(1'b0, `PSR_OFF_STAT, 32'h0000_0000);
    check("status after reset", rd, 32'h0000_0000);
    $display("mid-run reset test done");
    give_verdict();
  end
endmodule
